// >>> hdl/ubdl_regs.vh
// Purpose: constants for the bulk / done-queue pointer block
// Assumes: 32-bit register port, byte addresses
// Notes:   definitions only
`ifndef UBDL_REGS_VH
`define UBDL_REGS_VH
`define UBDL_OFS_CTRL_HEAD  8'h20
`define UBDL_OFS_CTRL_CUR   8'h24
`define UBDL_OFS_BULK_HEAD  8'h28
`define UBDL_OFS_BULK_CUR   8'h2c
`define UBDL_OFS_DONE_HEAD  8'h30
`define UBDL_OFS_INT_STAT   8'h40
`define UBDL_OFS_INT_MASK   8'h44
`define UBDL_OFS_CTRL       8'h48
`define UBDL_PTR_LSB        4
`define UBDL_PTR_RST        28'h0000000
`define UBDL_INT_WDH        0
`define UBDL_INT_BULK_WRAP  1
`define UBDL_INT_CTRL_WRAP  2
`define UBDL_INT_W          3
`define UBDL_CTRL_BLE       0
`define UBDL_CTRL_CLE       1
`define UBDL_CTRL_BLF       2
`define UBDL_CTRL_CLF       3
`define UBDL_CTRL_W         4
`endif

// >>> hdl/ubdl_list_ptr.v
// Purpose: one list's head and current endpoint pointer pair
// Assumes: single clock, synchronous inputs
// Notes:   used for both bulk and control lists
`timescale 1ns/100ps
`default_nettype none
`include "ubdl_regs.vh"
module ubdl_list_ptr (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire        i_head_wr,
  input  wire        i_head_load,
  input  wire [27:0] i_head_val,
  input  wire        i_cur_wr,
  input  wire [27:0] i_cur_wval,
  input  wire        i_advance,
  input  wire [27:0] i_next_val,
  input  wire        i_end_reached,
  input  wire        i_filled,
  output reg  [27:0] o_head,
  output reg  [27:0] o_cur,
  output wire        o_wrap
);
  // wrap only when the filled flag says new work was queued
  assign o_wrap = i_end_reached & i_filled;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_head <= `UBDL_PTR_RST;
      o_cur  <= `UBDL_PTR_RST;
    end else if (i_ce) begin
      if (i_head_wr || i_head_load)
        o_head <= i_head_val;
      if (o_wrap)
        o_cur <= o_head;
      else if (i_advance)
        o_cur <= i_next_val;
      else if (i_cur_wr)
        o_cur <= i_cur_wval;
    end
  end
endmodule // ubdl_list_ptr
`default_nettype wire

// >>> hdl/ubdl_ptrs.v
// Purpose: bulk / control list pointers and done-queue head of a usb host
// Assumes: list walker and memory engine outside; register port 32-bit
// Notes:   current pointer persists across frames; zero marks list end
//
// Contract
// - each bulk traversal starts at the head pointer's upper 28 bits.
// - at initialization the bulk head is loaded from the shared area.
// - bulk endpoints are served round-robin in insertion order.
// - after serving an endpoint the current pointer moves to the next.
// - a new frame resumes at the current pointer, not at the head.
// - at bulk list end, if filled is set copy head to current and clear it.
// - the bulk current pointer resets to zero, which means end of list.
// - a completed descriptor first gets the done head in its link field.
// - then the done head takes the completed descriptor's address.
// - writing the done head to the shared area clears it to zero.
// - each done head writeback sets the writeback-done status flag.
// - at control list end, if filled is set copy head and clear it.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ubdl_regs.vh"
module ubdl_ptrs (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_init_load,
  input  wire [31:0] i_init_bulk_head,
  input  wire [31:0] i_init_ctrl_head,
  input  wire        i_bulk_served,
  input  wire [31:0] i_bulk_next,
  input  wire        i_ctrl_served,
  input  wire [31:0] i_ctrl_next,
  input  wire        i_td_done,
  input  wire [31:0] i_td_addr,
  input  wire        i_link_ack,
  input  wire        i_wb_req,
  input  wire        i_wb_ack,
  output reg         o_link_req,
  output reg  [31:0] o_link_addr,
  output reg  [31:0] o_link_data,
  output reg         o_wb_req,
  output reg  [31:0] o_wb_data,
  output wire        o_busy,
  output wire [31:0] o_bulk_cur,
  output wire [31:0] o_ctrl_cur,
  output wire        o_bulk_enable,
  output wire        o_ctrl_enable,
  output wire        o_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LINK = 2'h1;
  localparam ST_WB   = 2'h2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [27:0] done_head;
  reg  [27:0] pend_td;
  reg  [`UBDL_INT_W-1:0]  int_stat;
  reg  [`UBDL_INT_W-1:0]  int_mask;
  reg  [`UBDL_CTRL_W-1:0] ctrl;
  wire [27:0] bulk_head;
  wire [27:0] bulk_cur;
  wire [27:0] ctrl_head;
  wire [27:0] ctrl_cur;
  wire        bulk_wrap;
  wire        ctrl_wrap;
  wire        wr_bh;
  wire        wr_bc;
  wire        wr_ch;
  wire        wr_cc;
  wire        wr_ctl;
  wire        bulk_end;
  wire        ctrl_end;
  wire        wb_done;
  wire [`UBDL_INT_W-1:0] int_set;

  assign wr_bh = i_wr && (i_addr == `UBDL_OFS_BULK_HEAD);
  assign wr_ch = i_wr && (i_addr == `UBDL_OFS_CTRL_HEAD);
  assign wr_ctl = i_wr && (i_addr == `UBDL_OFS_CTRL);
  // current pointer writes are dropped while the list runs
  assign wr_bc = i_wr && (i_addr == `UBDL_OFS_BULK_CUR)
                 && !ctrl[`UBDL_CTRL_BLE];
  assign wr_cc = i_wr && (i_addr == `UBDL_OFS_CTRL_CUR)
                 && !ctrl[`UBDL_CTRL_CLE];
  // zero current pointer stands for end of list
  assign bulk_end = i_bulk_served && (i_bulk_next[31:4] == 28'h0000000);
  assign ctrl_end = i_ctrl_served && (i_ctrl_next[31:4] == 28'h0000000);
  assign wb_done  = (state == ST_WB) && i_wb_ack;

  ubdl_list_ptr u_bulk (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .i_ce          (i_ce),
    .i_head_wr     (wr_bh),
    .i_head_load   (i_init_load),
    .i_head_val    (i_init_load ? i_init_bulk_head[31:4]
                                : i_wdata[31:4]),
    .i_cur_wr      (wr_bc),
    .i_cur_wval    (i_wdata[31:4]),
    .i_advance     (i_bulk_served),
    .i_next_val    (i_bulk_next[31:4]),
    .i_end_reached (bulk_end),
    .i_filled      (ctrl[`UBDL_CTRL_BLF]),
    .o_head        (bulk_head),
    .o_cur         (bulk_cur),
    .o_wrap        (bulk_wrap)
  );

  ubdl_list_ptr u_ctrl (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .i_ce          (i_ce),
    .i_head_wr     (wr_ch),
    .i_head_load   (i_init_load),
    .i_head_val    (i_init_load ? i_init_ctrl_head[31:4]
                                : i_wdata[31:4]),
    .i_cur_wr      (wr_cc),
    .i_cur_wval    (i_wdata[31:4]),
    .i_advance     (i_ctrl_served),
    .i_next_val    (i_ctrl_next[31:4]),
    .i_end_reached (ctrl_end),
    .i_filled      (ctrl[`UBDL_CTRL_CLF]),
    .o_head        (ctrl_head),
    .o_cur         (ctrl_cur),
    .o_wrap        (ctrl_wrap)
  );

  // frame boundaries never touch the current pointer, so the walker resumes
  assign o_bulk_cur    = {bulk_cur, 4'h0};
  assign o_ctrl_cur    = {ctrl_cur, 4'h0};
  assign o_bulk_enable = ctrl[`UBDL_CTRL_BLE];
  assign o_ctrl_enable = ctrl[`UBDL_CTRL_CLE];
  assign o_busy        = (state != ST_IDLE);
  assign o_irq         = |(int_stat & int_mask);
  assign int_set       = {ctrl_wrap, bulk_wrap, wb_done};

  // a new completion is refused (busy) until the previous one is linked
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_td_done)
          next_state = ST_LINK;
        else if (i_wb_req)
          next_state = ST_WB;
      end
      ST_LINK: begin
        if (i_link_ack)
          next_state = ST_IDLE;
      end
      ST_WB: begin
        if (i_wb_ack)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state       <= ST_IDLE;
      done_head   <= `UBDL_PTR_RST;
      pend_td     <= `UBDL_PTR_RST;
      o_link_req  <= 1'b0;
      o_link_addr <= 32'h00000000;
      o_link_data <= 32'h00000000;
      o_wb_req    <= 1'b0;
      o_wb_data   <= 32'h00000000;
    end else if (i_ce) begin
      state <= next_state;
      if (state == ST_IDLE && i_td_done) begin
        pend_td     <= i_td_addr[31:4];
        o_link_req  <= 1'b1;
        o_link_addr <= {i_td_addr[31:4], 4'h0};
        o_link_data <= {done_head, 4'h0};
      end else if (state == ST_IDLE && i_wb_req) begin
        o_wb_req  <= 1'b1;
        o_wb_data <= {done_head, 4'h0};
      end
      if (state == ST_LINK && i_link_ack) begin
        o_link_req <= 1'b0;
        done_head  <= pend_td;
      end
      if (wb_done) begin
        o_wb_req  <= 1'b0;
        done_head <= `UBDL_PTR_RST;
      end
    end
  end

  // control, status and mask; hardware sets win over software clears
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_stat <= {`UBDL_INT_W{1'b0}};
      int_mask <= {`UBDL_INT_W{1'b0}};
      ctrl     <= {`UBDL_CTRL_W{1'b0}};
      o_rdata  <= 32'h00000000;
    end else if (i_ce) begin
      if (i_rd && i_addr == `UBDL_OFS_INT_STAT)
        int_stat <= int_set;
      else
        int_stat <= int_stat | int_set;
      if (i_wr && i_addr == `UBDL_OFS_INT_MASK)
        int_mask <= i_wdata[`UBDL_INT_W-1:0];
      if (wr_ctl)
        ctrl <= i_wdata[`UBDL_CTRL_W-1:0];
      // a fresh software set of a filled bit outlives a wrap in that cycle
      if (bulk_wrap && !(wr_ctl && i_wdata[`UBDL_CTRL_BLF]))
        ctrl[`UBDL_CTRL_BLF] <= 1'b0;
      if (ctrl_wrap && !(wr_ctl && i_wdata[`UBDL_CTRL_CLF]))
        ctrl[`UBDL_CTRL_CLF] <= 1'b0;
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `UBDL_OFS_CTRL_HEAD: o_rdata <= {ctrl_head, 4'h0};
          `UBDL_OFS_CTRL_CUR:  o_rdata <= {ctrl_cur, 4'h0};
          `UBDL_OFS_BULK_HEAD: o_rdata <= {bulk_head, 4'h0};
          `UBDL_OFS_BULK_CUR:  o_rdata <= {bulk_cur, 4'h0};
          `UBDL_OFS_DONE_HEAD: o_rdata <= {done_head, 4'h0};
          `UBDL_OFS_INT_STAT:  o_rdata <= {29'h0, int_stat};
          `UBDL_OFS_INT_MASK:  o_rdata <= {29'h0, int_mask};
          `UBDL_OFS_CTRL:      o_rdata <= {28'h0, ctrl};
          default:             o_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // ubdl_ptrs
`default_nettype wire

// >>> tb/ubdl_mem_model.sv
// Purpose: system memory answering link and writeback writes
// Assumes: one write outstanding at a time
// Notes:   i_slow delays each ack by four extra cycles
`timescale 1ns/100ps
`default_nettype none
module ubdl_mem_model (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_slow,
  input  wire        i_link_req,
  input  wire [31:0] i_link_data,
  input  wire        i_wb_req,
  input  wire [31:0] i_wb_data,
  output logic       o_link_ack,
  output logic       o_wb_ack,
  output logic [31:0] o_td_link,
  output logic [31:0] o_hcca_done
);
  logic [2:0] wait_cnt;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_link_ack <= 1'b0;
      o_wb_ack <= 1'b0;
      wait_cnt <= 3'h0;
      o_td_link <= 32'hffff_ffff;
      o_hcca_done <= 32'hffff_ffff;
    end else begin
      o_link_ack <= 1'b0;
      o_wb_ack <= 1'b0;
      // a fresh ack only once the last one has been seen
      if ((i_link_req || i_wb_req) && !o_link_ack && !o_wb_ack) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (!i_slow || wait_cnt == 3'h4) begin
          wait_cnt <= 3'h0;
          o_link_ack <= i_link_req;
          o_wb_ack <= i_wb_req;
          if (i_link_req) o_td_link <= i_link_data;
          if (i_wb_req) o_hcca_done <= i_wb_data;
        end
      end
    end
  end
endmodule // ubdl_mem_model
`default_nettype wire

// >>> tb/ubdl_ptrs_chk.sv
// Purpose: port checker for the pointer block
// Assumes: bound to ubdl_ptrs
// Notes:   clock enable low freezes state, so checks pause
`timescale 1ns/100ps
`default_nettype none
module ubdl_ptrs_chk (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire        i_ce,
  input wire        i_td_done,
  input wire [31:0] i_td_addr,
  input wire        i_wb_req,
  input wire        i_wb_ack,
  input wire        i_link_ack,
  input wire        i_bulk_served,
  input wire [31:0] i_bulk_next,
  input wire        o_link_req,
  input wire [31:0] o_link_addr,
  input wire [31:0] o_link_data,
  input wire        o_wb_req,
  input wire        o_busy,
  input wire [31:0] o_bulk_cur,
  input wire [31:0] o_ctrl_cur
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n || !i_ce);
  link_start_a: assert property (i_td_done && !o_busy |=> o_link_req &&
    o_link_addr == ($past(i_td_addr) & 32'hffff_fff0)) else $error("no link");
  link_hold_a: assert property (o_link_req && !i_link_ack |=>
    o_link_req && $stable(o_link_data)) else $error("link dropped");
  link_end_a: assert property (o_link_req && i_link_ack |=> !o_link_req)
    else $error("link stuck");
  wb_start_a: assert property (i_wb_req && !i_td_done && !o_busy
    |=> o_wb_req) else $error("no writeback");
  wb_end_a: assert property (o_wb_req && i_wb_ack |=> !o_wb_req)
    else $error("writeback stuck");
  busy_map_a: assert property (o_busy == (o_link_req || o_wb_req))
    else $error("busy wrong");
  bulk_adv_a: assert property (i_bulk_served && |i_bulk_next[31:4] |=>
    o_bulk_cur == ($past(i_bulk_next) & 32'hffff_fff0)) else $error("no adv");
  ptr_align_a: assert property (o_bulk_cur[3:0] == 4'h0 &&
    o_ctrl_cur[3:0] == 4'h0 && o_link_addr[3:0] == 4'h0) else $error("align");
endmodule // ubdl_ptrs_chk
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the pointer block
// Assumes: clock enable dropped once to check that state freezes
// Notes:   memory model answers promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, init = 0, bs = 0, cs = 0;
  logic td = 0, wbr = 0, slow = 0, ce = 1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 0, nxt = 0, tda = 0, ihead = 0;
  wire [31:0] rdata, laddr, ldata, wbd, bcur, ccur, tdl, hcca;
  wire lreq, lack, wreq, wack, busy, ben, cen, irq;
  int errors = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  ubdl_ptrs u_ubdl_ptrs (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_init_load(init), .i_init_bulk_head(ihead), .i_init_ctrl_head(ihead),
    .i_bulk_served(bs), .i_bulk_next(nxt), .i_ctrl_served(cs),
    .i_ctrl_next(nxt), .i_td_done(td), .i_td_addr(tda), .i_link_ack(lack),
    .i_wb_req(wbr), .i_wb_ack(wack), .o_link_req(lreq), .o_link_addr(laddr),
    .o_link_data(ldata), .o_wb_req(wreq), .o_wb_data(wbd), .o_busy(busy),
    .o_bulk_cur(bcur), .o_ctrl_cur(ccur), .o_bulk_enable(ben),
    .o_ctrl_enable(cen), .o_irq(irq));
  ubdl_mem_model u_ubdl_mem_model (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_slow(slow), .i_link_req(lreq), .i_link_data(ldata), .i_wb_req(wreq),
    .i_wb_data(wbd), .o_link_ack(lack), .o_wb_ack(wack), .o_td_link(tdl),
    .o_hcca_done(hcca));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); addr <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    #1 chk(rdata, e);
  endtask
  // one served pulse; ctrl picks the control list
  task serve(input logic ctrl, input logic [31:0] n);
    @(posedge clk); nxt <= n; bs <= !ctrl; cs <= ctrl;
    @(posedge clk); bs <= 0; cs <= 0;
    #1;
  endtask
  task mem_op(input logic is_wb, input logic [31:0] a);
    @(posedge clk); tda <= a; td <= !is_wb; wbr <= is_wb;
    @(posedge clk); td <= 0; wbr <= 0;
    #1;
    repeat (40) if (busy !== 1'b0) begin @(posedge clk); #1; end
    if (busy !== 1'b0) begin errors++; $display("ERROR %0t: hang", $time);
      report_and_stop; end
  endtask
  task t_heads;
    rd_reg(8'h2c, 0); rd_reg(8'h30, 0); rd_reg(8'h3c, 0);
    @(posedge clk); ihead <= 32'h1234_567f; init <= 1;
    @(posedge clk); init <= 0;
    rd_reg(8'h28, 32'h1234_5670);
    wr_reg(8'h28, 32'h0000_a00f);
    rd_reg(8'h28, 32'h0000_a000);
    $display("heads done");
  endtask
  task t_bulk;
    wr_reg(8'h48, 32'h5);
    #1 chk(ben, 1);
    wr_reg(8'h2c, 32'h0000_0990);
    #1 chk(bcur, 0);
    serve(0, 32'h100); chk(bcur, 32'h100);
    serve(0, 32'h20f); chk(bcur, 32'h200);
    rd_reg(8'h2c, 32'h200);
    serve(0, 0); chk(bcur, 32'ha000);
    rd_reg(8'h48, 32'h1);
    chk(irq, 0);
    rd_reg(8'h40, 32'h2);
    serve(0, 0); chk(bcur, 0);
    @(posedge clk); ce <= 0;
    serve(0, 32'h300); chk(bcur, 0);
    @(posedge clk); ce <= 1;
    $display("bulk done");
  endtask
  task t_ctrl;
    wr_reg(8'h20, 32'h0000_b000);
    wr_reg(8'h48, 32'ha);
    #1 chk(cen, 1);
    chk(ben, 0);
    serve(1, 0); chk(ccur, 32'hb000);
    rd_reg(8'h48, 32'h2);
    rd_reg(8'h40, 32'h4);
    $display("ctrl done");
  endtask
  task t_done;
    wr_reg(8'h44, 32'h1);
    slow <= 1;
    mem_op(0, 32'h0000_c00f); chk(tdl, 0);
    chk(laddr, 32'hc000);
    rd_reg(8'h30, 32'hc000);
    slow <= 0;
    mem_op(0, 32'h0000_d000); chk(tdl, 32'hc000);
    chk(laddr, 32'hd000);
    mem_op(1, 0); chk(hcca, 32'hd000);
    rd_reg(8'h30, 0);
    chk(irq, 1);
    rd_reg(8'h40, 32'h1);
    chk(irq, 0);
    $display("done queue done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    t_heads; t_bulk; t_ctrl; t_done;
    report_and_stop;
  end
endmodule // tb_top
bind ubdl_ptrs ubdl_ptrs_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_td_done(i_td_done), .i_td_addr(i_td_addr),
  .i_wb_req(i_wb_req), .i_wb_ack(i_wb_ack), .i_link_ack(i_link_ack),
  .i_bulk_served(i_bulk_served), .i_bulk_next(i_bulk_next),
  .o_link_req(o_link_req), .o_link_addr(o_link_addr),
  .o_link_data(o_link_data), .o_wb_req(o_wb_req), .o_busy(o_busy),
  .o_bulk_cur(o_bulk_cur), .o_ctrl_cur(o_ctrl_cur));
`default_nettype wire
